// ==== include/scr_pkg.sv ====
package scr_pkg;

    // ==============================================================
    // device variants
    // ==============================================================
    localparam logic [1:0] VAR_BASIC = 2'h0; // one divider, timer-select
    localparam logic [1:0] VAR_TWO_DIV = 2'h1; // two dividers, no remap
    localparam logic [1:0] VAR_FULL = 2'h2; // remap, pwm, halt control

    // ==============================================================
    // register byte offsets
    // ==============================================================
    localparam logic [7:0] OFF_SYSTEM_CONTROL_0_BASIC = 8'h00;
    localparam logic [7:0] OFF_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL = 8'h04;
    localparam logic [7:0] OFF_HALT_SLOW_CRYSTAL_CONTROL = 8'h08;

    // ==============================================================
    // reset values
    // ==============================================================
    localparam logic [7:0] RST_SYSTEM_CONTROL_0_BASIC = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL = 8'h8A;
    localparam logic [7:0] RST_HALT_SLOW_CRYSTAL_CONTROL = 8'h01;

    // ==============================================================
    // implemented-bit masks per variant
    // ==============================================================
    localparam logic [7:0] MASK_SYSTEM_CONTROL_0_BASIC_BASIC = 8'h47;
    localparam logic [7:0] MASK_SYSTEM_CONTROL_0_BASIC_TWO_DIV = 8'h0F;
    localparam logic [7:0] MASK_SYSTEM_CONTROL_0_BASIC_FULL = 8'hFF;
    localparam logic [7:0] MASK_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL = 8'hFF;
    localparam logic [7:0] MASK_HALT_SLOW_CRYSTAL_CONTROL_FULL = 8'h01;
    localparam logic [7:0] MASK_HALT_SLOW_CRYSTAL_CONTROL_OTHER = 8'h00;

    // ==============================================================
    // control word 0 fields
    // ==============================================================
    localparam int C0_SYSCLK_SPEED = 0;
    localparam int C0_SLOW_XTAL_LP = 1;
    localparam int C0_DIV_PIN = 2;
    localparam int C0_DIV_EN_LO = 2;
    localparam int C0_DIV_EN_HI = 3;
    localparam int C0_PULSE0 = 3;
    localparam int C0_PULSE1 = 4;
    localparam int C0_PULSE_FMT = 5;
    localparam int C0_DIV_SRC = 6;
    localparam int C0_REMAP = 7;

    // divider-enable codes of the two-divider variant
    localparam logic [1:0] DIV_NONE = 2'h0;
    localparam logic [1:0] DIV_RSVD = 2'h1;
    localparam logic [1:0] DIV_FIRST = 2'h2;
    localparam logic [1:0] DIV_BOTH = 2'h3;

    // ==============================================================
    // control word 1 fields
    // ==============================================================
    localparam int C1_EDGE_LO = 6;
    localparam int C1_TICK_LO = 4;
    localparam int C1_KEY_LO = 0;
    localparam logic [3:0] WDT_OFF_KEY = 4'hA;

    // ==============================================================
    // control word 2 fields
    // ==============================================================
    localparam int C2_HALT_KEEP = 0;

endpackage

// ==== src/scr_regs.sv ====
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
// Operation
// - two-divider variant: enable code 00 none, 10 first, 11 both outputs.
// - a disabled divider output leaves its pin as ordinary gpio.
// - control0 bit1: 0 quick-start, 1 low-power slow crystal.
// - control0 bit0: 1 runs from slow crystal and stops fast rc.
// - clock select acts only when fast-plus-slow crystal option chosen.
// - full variant bit7 remaps irq, timer0 input, divider pins to port b.
// - bit6 picks divider clock: 0 timer0, 1 timer1.
// - bit5 picks pwm split: 0 six-plus-two, 1 seven-plus-one.
// - bits 4,3,2 route pwm1, pwm0, divider to pins when set.
// - full variant clock select 1 stops whichever fast oscillator is chosen.
// - any pwm output enabled forces peripheral clock from system clock.
// - control1 bits 7..6: off, rising, falling, both edges.
// - control1 bits 5..4: tick period 2^10 to 2^13 peripheral clocks.
// - watchdog forced on by option; then key is ignored.
// - control2 bit0: slow crystal off (0) or kept (1) during halt.
// - unimplemented bits ignore writes and read zero.
// - fast oscillator always stops in sleep or idle.
module scr_regs #(
    parameter logic [1:0] VARIANT = scr_pkg::VAR_FULL
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cyc_in,
    input wire logic stb_in,
    input wire logic we_in,
    input wire logic [7:0] adr_in,
    input wire logic [3:0] sel_in,
    input wire logic [31:0] dat_in,
    output logic [31:0] dat_out,
    output logic ack_out,
    input wire logic cfg_slow_xtal_option_in,
    input wire logic cfg_watchdog_force_in,
    input wire logic halt_in,
    output logic sysclk_slow_sel_out,
    output logic fast_osc_run_out,
    output logic slow_crystal_osc_run_out,
    output logic slow_crystal_low_power_out,
    output logic divider_a_pin_en_out,
    output logic divider_b_pin_en_out,
    output logic pulse_out0_pin_en_out,
    output logic pulse_out1_pin_en_out,
    output logic pin_remap_select_out,
    output logic divider_clock_source_out,
    output logic pulse_width_format_out,
    output logic peripheral_clock_from_sys_out,
    output logic [1:0] ext_irq_edge_out,
    output logic [1:0] tick_period_sel_out,
    output logic watchdog_enable_out
);

    // ==============================================================
    // variant masks
    // ==============================================================
    localparam logic [7:0] MASK0 = (VARIANT == scr_pkg::VAR_FULL) ? scr_pkg::MASK_SYSTEM_CONTROL_0_BASIC_FULL :
        (VARIANT == scr_pkg::VAR_TWO_DIV) ? scr_pkg::MASK_SYSTEM_CONTROL_0_BASIC_TWO_DIV :
        scr_pkg::MASK_SYSTEM_CONTROL_0_BASIC_BASIC;
    localparam logic [7:0] MASK2 = (VARIANT == scr_pkg::VAR_FULL) ?
        scr_pkg::MASK_HALT_SLOW_CRYSTAL_CONTROL_FULL : scr_pkg::MASK_HALT_SLOW_CRYSTAL_CONTROL_OTHER;
    localparam logic IS_FULL = (VARIANT == scr_pkg::VAR_FULL);
    localparam logic IS_TWO = (VARIANT == scr_pkg::VAR_TWO_DIV);

    logic [7:0] system_control_0_basic_ff;
    logic [7:0] interrupt_timebase_watchdog_control_ff;
    logic [7:0] halt_slow_crystal_control_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic req;
    logic wr_now;
    logic [7:0] nxt_rdat;
    logic [1:0] div_code;
    logic clk_sel_ok;

    // ==============================================================
    // wishbone slave
    // ==============================================================
    // one wait state: ack rises the cycle after the request is seen
    assign req = cyc_in & stb_in;
    assign wr_now = req & ack_ff & we_in & sel_in[0];
    assign ack_out = ack_ff;
    assign dat_out = rdat_ff;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // unmapped offsets answer with zero and drop writes
    always_comb begin
        case (adr_in)
            scr_pkg::OFF_SYSTEM_CONTROL_0_BASIC: nxt_rdat = system_control_0_basic_ff & MASK0;
            scr_pkg::OFF_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL: nxt_rdat = interrupt_timebase_watchdog_control_ff & scr_pkg::MASK_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL;
            scr_pkg::OFF_HALT_SLOW_CRYSTAL_CONTROL: nxt_rdat = halt_slow_crystal_control_ff & MASK2;
            default: nxt_rdat = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdat_ff <= 32'h0000_0000;
        end else if (req & ~ack_ff) begin
            rdat_ff <= {24'h00_0000, nxt_rdat};
        end
    end

    // ==============================================================
    // control registers
    // ==============================================================
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            system_control_0_basic_ff <= scr_pkg::RST_SYSTEM_CONTROL_0_BASIC & MASK0;
        end else if (wr_now && adr_in == scr_pkg::OFF_SYSTEM_CONTROL_0_BASIC) begin
            system_control_0_basic_ff <= dat_in[7:0] & MASK0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            interrupt_timebase_watchdog_control_ff <= scr_pkg::RST_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL;
        end else if (wr_now && adr_in == scr_pkg::OFF_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL) begin
            interrupt_timebase_watchdog_control_ff <= dat_in[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            halt_slow_crystal_control_ff <= scr_pkg::RST_HALT_SLOW_CRYSTAL_CONTROL & MASK2;
        end else if (wr_now && adr_in == scr_pkg::OFF_HALT_SLOW_CRYSTAL_CONTROL) begin
            halt_slow_crystal_control_ff <= dat_in[7:0] & MASK2;
        end
    end

    // ==============================================================
    // clock control
    // ==============================================================
    assign clk_sel_ok = cfg_slow_xtal_option_in;
    // without the slow crystal option the speed bit is stored but inert
    assign sysclk_slow_sel_out = clk_sel_ok & system_control_0_basic_ff[scr_pkg::C0_SYSCLK_SPEED];
    // slow selection stops the fast source; halt always stops it
    assign fast_osc_run_out = ~sysclk_slow_sel_out & ~halt_in;
    assign slow_crystal_low_power_out = system_control_0_basic_ff[scr_pkg::C0_SLOW_XTAL_LP];
    // smaller variants keep the slow crystal running through halt
    assign slow_crystal_osc_run_out = IS_FULL ?
        (~halt_in | halt_slow_crystal_control_ff[scr_pkg::C2_HALT_KEEP]) : 1'b1;

    // ==============================================================
    // pin function and divider/pwm selects
    // ==============================================================
    assign div_code = system_control_0_basic_ff[scr_pkg::C0_DIV_EN_HI:scr_pkg::C0_DIV_EN_LO];

    always_comb begin
        divider_a_pin_en_out = 1'b0;
        divider_b_pin_en_out = 1'b0;
        if (IS_TWO) begin
            case (div_code)
                scr_pkg::DIV_FIRST: begin
                    divider_a_pin_en_out = 1'b1;
                end
                scr_pkg::DIV_BOTH: begin
                    divider_a_pin_en_out = 1'b1;
                    divider_b_pin_en_out = 1'b1;
                end
                scr_pkg::DIV_RSVD: begin
                    divider_a_pin_en_out = 1'b0;
                end
                default: begin
                    divider_a_pin_en_out = 1'b0;
                end
            endcase
        end else begin
            divider_a_pin_en_out = system_control_0_basic_ff[scr_pkg::C0_DIV_PIN];
        end
    end

    assign pulse_out0_pin_en_out = IS_FULL & system_control_0_basic_ff[scr_pkg::C0_PULSE0];
    assign pulse_out1_pin_en_out = IS_FULL & system_control_0_basic_ff[scr_pkg::C0_PULSE1];
    assign pin_remap_select_out = IS_FULL & system_control_0_basic_ff[scr_pkg::C0_REMAP];
    assign pulse_width_format_out = IS_FULL & system_control_0_basic_ff[scr_pkg::C0_PULSE_FMT];
    assign divider_clock_source_out = ~IS_TWO & system_control_0_basic_ff[scr_pkg::C0_DIV_SRC];
    // pwm needs a steady fast timebase, so it overrides any slow choice
    assign peripheral_clock_from_sys_out = pulse_out0_pin_en_out | pulse_out1_pin_en_out;

    // ==============================================================
    // interrupt edge, tick period, watchdog
    // ==============================================================
    assign ext_irq_edge_out = interrupt_timebase_watchdog_control_ff[scr_pkg::C1_EDGE_LO +: 2];
    assign tick_period_sel_out = interrupt_timebase_watchdog_control_ff[scr_pkg::C1_TICK_LO +: 2];
    // only the exact key turns it off, so stray writes fail safe
    assign watchdog_enable_out = cfg_watchdog_force_in |
        (interrupt_timebase_watchdog_control_ff[scr_pkg::C1_KEY_LO +: 4] != scr_pkg::WDT_OFF_KEY);

    // ==============================================================
    // checks
    // ==============================================================
    default clocking chk_cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    chk_div_decode: assert property (
        IS_TWO |-> (divider_b_pin_en_out == (div_code == scr_pkg::DIV_BOTH)))
        else $error("second divider enable decoded wrongly");
    chk_div_reserved: assert property (
        (IS_TWO && div_code == scr_pkg::DIV_RSVD) |-> !divider_a_pin_en_out)
        else $error("reserved divider code enabled an output");
    chk_div_gpio: assert property (
        (IS_TWO && div_code == scr_pkg::DIV_NONE) |-> !(divider_a_pin_en_out | divider_b_pin_en_out))
        else $error("divider pin not returned to gpio");
    chk_lp_write: assert property (
        (wr_now && adr_in == scr_pkg::OFF_SYSTEM_CONTROL_0_BASIC) |=> slow_crystal_low_power_out == $past(dat_in[1]))
        else $error("low power bit did not follow write");
    chk_fast_stop: assert property (
        sysclk_slow_sel_out |-> !fast_osc_run_out)
        else $error("fast oscillator runs on slow clock");
    chk_clk_option: assert property (
        !cfg_slow_xtal_option_in |-> !sysclk_slow_sel_out)
        else $error("clock select acted without option");
    chk_remap_full: assert property (
        !IS_FULL |-> !pin_remap_select_out)
        else $error("remap active on small variant");
    chk_tp_force: assert property (
        (pulse_out0_pin_en_out || pulse_out1_pin_en_out) |-> peripheral_clock_from_sys_out)
        else $error("pwm on without system peripheral clock");
    chk_edge_write: assert property (
        (wr_now && adr_in == scr_pkg::OFF_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL) |=> ext_irq_edge_out == $past(dat_in[7:6]))
        else $error("edge field did not follow write");
    chk_tick_hold: assert property (
        !(wr_now && adr_in == scr_pkg::OFF_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL) |=> $stable(tick_period_sel_out))
        else $error("tick period changed without write");
    chk_wdt_force: assert property (
        cfg_watchdog_force_in |-> watchdog_enable_out)
        else $error("watchdog off while forced");
    chk_wdt_key: assert property (
        (!cfg_watchdog_force_in && interrupt_timebase_watchdog_control_ff[3:0] == 4'hA) |-> !watchdog_enable_out)
        else $error("watchdog on with off key");
    chk_halt_keep: assert property (
        (IS_FULL && halt_in) |-> (slow_crystal_osc_run_out == halt_slow_crystal_control_ff[0]))
        else $error("slow crystal halt control wrong");
    chk_unimpl_zero: assert property (
        (ack_ff && adr_in == scr_pkg::OFF_HALT_SLOW_CRYSTAL_CONTROL) |-> (rdat_ff[7:1] == 7'h00))
        else $error("unimplemented bits read nonzero");
    chk_halt_fast: assert property (
        halt_in |-> !fast_osc_run_out)
        else $error("fast oscillator runs during halt");
    chk_ack_pulse: assert property (
        req && !ack_ff |=> ack_ff ##1 !ack_ff)
        else $error("ack not a single cycle pulse");

    cov_slow_mode: cover property (sysclk_slow_sel_out ##1 !sysclk_slow_sel_out);
    cov_wdt_off: cover property (watchdog_enable_out ##1 !watchdog_enable_out);
    cov_halt_keep: cover property (halt_in && slow_crystal_osc_run_out);
    cov_pwm_force: cover property (peripheral_clock_from_sys_out);

endmodule

// ==== test/tb_system_control_registers.sv ====
`timescale 1ns/1ps
module tb_system_control_registers;
    // ==============================================================
    // stimulus and observation
    // ==============================================================
    localparam int CYCLE_LIMIT = 3000;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h00000000;
    logic opt = 1'b1;
    logic wdf = 1'b0;
    logic halt = 1'b0;
    logic [31:0] dat_f, dat_t, rd_f, rd_t;
    logic ack_f, ack_t, ack_tw;
    logic slow_sel, fast_run, lxt_run, lp, div_a, div_b, p0, p1, remap, dsrc, fmt, pclk, wdt;
    logic t_div_a, t_div_b;
    logic [1:0] irq_edge, tick_o;
    logic [3:0] keys [4] = '{4'hA, 4'h5, 4'hB, 4'h2};
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;

    scr_regs #(.VARIANT(scr_pkg::VAR_FULL)) dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cyc_in(cyc), .stb_in(stb), .we_in(we),
        .adr_in(adr), .sel_in(sel), .dat_in(wdat), .dat_out(dat_f), .ack_out(ack_f),
        .cfg_slow_xtal_option_in(opt), .cfg_watchdog_force_in(wdf), .halt_in(halt),
        .sysclk_slow_sel_out(slow_sel), .fast_osc_run_out(fast_run),
        .slow_crystal_osc_run_out(lxt_run), .slow_crystal_low_power_out(lp),
        .divider_a_pin_en_out(div_a), .divider_b_pin_en_out(div_b),
        .pulse_out0_pin_en_out(p0), .pulse_out1_pin_en_out(p1),
        .pin_remap_select_out(remap), .divider_clock_source_out(dsrc),
        .pulse_width_format_out(fmt), .peripheral_clock_from_sys_out(pclk),
        .ext_irq_edge_out(irq_edge), .tick_period_sel_out(tick_o), .watchdog_enable_out(wdt));

    // second variant shares the bus; its acks track the first one's
    scr_regs #(.VARIANT(scr_pkg::VAR_TWO_DIV)) dut_two_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cyc_in(cyc), .stb_in(stb), .we_in(we),
        .adr_in(adr), .sel_in(sel), .dat_in(wdat), .dat_out(dat_t), .ack_out(ack_t),
        .cfg_slow_xtal_option_in(opt), .cfg_watchdog_force_in(wdf), .halt_in(halt),
        .sysclk_slow_sel_out(), .fast_osc_run_out(), .slow_crystal_osc_run_out(),
        .slow_crystal_low_power_out(), .divider_a_pin_en_out(t_div_a),
        .divider_b_pin_en_out(t_div_b), .pulse_out0_pin_en_out(), .pulse_out1_pin_en_out(),
        .pin_remap_select_out(), .divider_clock_source_out(), .pulse_width_format_out(),
        .peripheral_clock_from_sys_out(), .ext_irq_edge_out(), .tick_period_sel_out(),
        .watchdog_enable_out());

    always #25 clk_in = ~clk_in;

    // ==============================================================
    // tasks
    // ==============================================================
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // entered just after a rising edge; leaves one idle cycle behind it
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d,
                            input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= {24'h000000, d};
        do @(posedge clk_in); while (ack_f !== 1'b1);
        rd_f = dat_f;
        rd_t = dat_t;
        ack_tw = ack_t;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb_cycle(1'b1, a, d, 4'h1);
    endtask

    task automatic rd(input logic [7:0] a);
        wb_cycle(1'b0, a, 8'h00, 4'hF);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end

    // ==============================================================
    // tests
    // ==============================================================
    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        rd(scr_pkg::OFF_SYSTEM_CONTROL_0_BASIC);
        chk(rd_f, 32'h00000000);
        rd(scr_pkg::OFF_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL);
        chk(rd_f, 32'h0000008A);
        chk({irq_edge, wdt}, 3'b100);
        rd(scr_pkg::OFF_HALT_SLOW_CRYSTAL_CONTROL);
        chk(rd_f, 32'h00000001);
        chk(rd_t, 32'h00000000);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            logic [7:0] bit_v;
            bit_v = 8'h01 << i;
            wr(scr_pkg::OFF_SYSTEM_CONTROL_0_BASIC, bit_v);
            rd(scr_pkg::OFF_SYSTEM_CONTROL_0_BASIC);
            chk(rd_f, {24'h000000, bit_v});
            chk({remap, dsrc, fmt, p1, p0, div_a, lp, slow_sel}, bit_v);
            chk({div_b, pclk, fast_run}, {1'b0, i == 3 || i == 4, i != 0});
        end
        wr(scr_pkg::OFF_SYSTEM_CONTROL_0_BASIC, 8'h19);
        opt <= 1'b0;
        @(posedge clk_in);
        chk({slow_sel, fast_run, pclk}, 3'b011);
        halt <= 1'b1;
        @(posedge clk_in);
        chk(fast_run, 1'b0);
        $display("test control0 done");
        wr(scr_pkg::OFF_HALT_SLOW_CRYSTAL_CONTROL, 8'hFF);
        rd(scr_pkg::OFF_HALT_SLOW_CRYSTAL_CONTROL);
        chk(rd_f, 32'h00000001);
        chk(lxt_run, 1'b1);
        wr(scr_pkg::OFF_HALT_SLOW_CRYSTAL_CONTROL, 8'h00);
        chk(lxt_run, 1'b0);
        halt <= 1'b0;
        @(posedge clk_in);
        chk({lxt_run, fast_run}, 2'b11);
        $display("test control2 done");
        for (int k = 0; k < 4; k++) begin
            wr(scr_pkg::OFF_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL, {k[1:0], ~k[1:0], keys[k]});
            chk({irq_edge, tick_o, wdt}, {k[1:0], ~k[1:0], keys[k] != 4'hA});
        end
        wr(scr_pkg::OFF_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL, 8'h0A);
        chk(wdt, 1'b0);
        wdf <= 1'b1;
        @(posedge clk_in);
        chk(wdt, 1'b1);
        $display("test control1 done");
        for (int k = 0; k < 4; k++) begin
            wr(scr_pkg::OFF_SYSTEM_CONTROL_0_BASIC, {4'hF, k[1:0], 2'b00});
            rd(scr_pkg::OFF_SYSTEM_CONTROL_0_BASIC);
            chk(rd_t, {28'h0000000, k[1:0], 2'b00});
            chk({t_div_a, t_div_b}, {k[1], k == 3});
        end
        $display("test dividers done");
        // unmapped place and a write with its byte lane off must both be dropped
        wr(8'h0C, 8'h55);
        rd(8'h0C);
        chk(rd_f, 32'h00000000);
        chk(ack_tw, 1'b1);
        wb_cycle(1'b1, scr_pkg::OFF_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL, 8'h00, 4'hE);
        rd(scr_pkg::OFF_INTERRUPT_TIMEBASE_WATCHDOG_CONTROL);
        chk(rd_f, 32'h0000000A);
        $display("test refused done");
        complete_run();
    end
endmodule
